/* hw/link_req_pkg.sv */
package link_req_pkg;

	// request kinds
	typedef enum logic [2:0] {
		REQ_BLOCK_SEND_COORD = 3'h0,
		REQ_BLOCK_SEND_MAILBOX = 3'h1,
		REQ_REMOTE_WRITE = 3'h2,
		REQ_REMOTE_READ = 3'h3,
		REQ_PRINT = 3'h4,
		REQ_BLOCK_RECEIVE = 3'h5
	} req_kind_e;

	typedef enum logic [1:0] {
		PROTO_HANDSHAKE = 2'h0,
		PROTO_COMPUTER_LINK = 2'h1,
		PROTO_PRINTER = 2'h2
	} proto_e;

	// transfer length limits in bytes
	localparam logic [12:0] LEN_MAX_4K = 13'h1000;
	localparam logic [12:0] LEN_MAX_LINK_SHORT = 13'h01C2;
	localparam logic [12:0] LEN_MAX_PRINT = 13'h0190;

	// status word values
	localparam logic [15:0] STAT_OK = 16'h0000;
	localparam logic [15:0] STAT_COMM_FAIL = 16'h0001;
	localparam logic [15:0] STAT_LENGTH = 16'h0004;
	localparam logic [15:0] STAT_RESET_DONE = 16'h0005;
	localparam logic [15:0] STAT_ACCESS_DENIED = 16'h0008;
	localparam logic [15:0] STAT_BUSY_WARN = 16'h000B;
	localparam logic [15:0] STAT_NO_PARAM = 16'h0010;
	localparam logic [15:0] STAT_HOST_STOPPED = 16'h0011;
	localparam logic [15:0] STAT_BAD_PROTO = 16'h0012;

	// event codes for the error area and log
	localparam logic [7:0] EVT_PARAM_ABORT = 8'h01;
	localparam logic [7:0] EVT_REQ_ERROR = 8'h02;
	localparam logic [7:0] EVT_PEER_ERROR = 8'h03;
	localparam logic [7:0] EVT_DIAG = 8'h04;

	localparam int LOG_DEPTH = 16;
	localparam int LOG_AW = 4;
	localparam int BUF_DEPTH = 2;

	typedef struct packed {
		req_kind_e kind;
		logic [12:0] length;
		logic [15:0] addr;
		logic dyn_addr;
	} req_s;

	typedef struct packed {
		logic done;
		logic error;
		logic [15:0] status;
	} resp_s;

	typedef struct packed {
		logic [7:0] code;
		logic [15:0] detail;
	} event_s;

	typedef struct packed {
		logic last;
		logic [7:0] data;
	} byte_s;

endpackage

/* hw/event_log_mem.sv */
`timescale 1ns/1ps
module event_log_mem (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// write side
	input wire logic i_wr,
	input wire link_req_pkg::event_s i_wr_evt,
	// read side
	input wire logic [link_req_pkg::LOG_AW-1:0] i_rd_idx,
	output link_req_pkg::event_s o_rd_evt,
	output logic [link_req_pkg::LOG_AW-1:0] o_wr_ptr
);
	import link_req_pkg::*;

	event_s mem [LOG_DEPTH];
	logic [LOG_AW-1:0] wr_ptr_r;
	event_s rd_r;

	// ring buffer: the oldest entry is overwritten once it wraps
	always_ff @(posedge i_clk) begin
		if (i_wr) begin
			mem[wr_ptr_r] <= i_wr_evt;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			wr_ptr_r <= '0;
		end else if (i_wr) begin
			wr_ptr_r <= wr_ptr_r + 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			rd_r <= '0;
		end else begin
			rd_r <= mem[i_rd_idx];
		end
	end

	assign o_rd_evt = rd_r;
	assign o_wr_ptr = wr_ptr_r;
endmodule

/* hw/skid_buffer2.sv */
`timescale 1ns/1ps
module skid_buffer2 (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_flush,
	// fill side
	input wire logic i_valid,
	input wire link_req_pkg::byte_s i_data,
	output logic o_ready,
	// drain side
	output logic o_valid,
	output link_req_pkg::byte_s o_data,
	input wire logic i_ready
);
	import link_req_pkg::*;

	byte_s slot_r [BUF_DEPTH];
	logic rd_r;
	logic wr_r;
	logic [1:0] cnt_r;
	logic push;
	logic pop;

	assign o_ready = (cnt_r != 2'h2);
	assign o_valid = (cnt_r != 2'h0);
	assign o_data = slot_r[rd_r];
	assign push = i_valid && o_ready;
	assign pop = o_valid && i_ready;

	always_ff @(posedge i_clk) begin
		if (push) begin
			slot_r[wr_r] <= i_data;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst || i_flush) begin
			rd_r <= 1'b0;
			wr_r <= 1'b0;
			cnt_r <= 2'h0;
		end else begin
			if (push) begin
				wr_r <= ~wr_r;
			end
			if (pop) begin
				rd_r <= ~rd_r;
			end
			cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule

/* hw/serial_link_request_manager.sv */
`timescale 1ns/1ps
module serial_link_request_manager (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// start-up
	input wire logic i_selftest_done,
	input wire logic i_selftest_fail,
	input wire logic i_param_load,
	input wire link_req_pkg::proto_e i_param_proto,
	// host mode
	input wire logic i_host_run,
	input wire logic i_cold_restart,
	// host request interface
	input wire logic i_req_trig,
	input wire link_req_pkg::req_s i_req,
	input wire logic i_tx_valid,
	input wire link_req_pkg::byte_s i_tx_data,
	output logic o_tx_ready,
	output link_req_pkg::resp_s o_resp,
	// serial side
	output logic o_ser_valid,
	output link_req_pkg::byte_s o_ser_data,
	input wire logic i_ser_ready,
	input wire logic i_ser_done,
	input wire logic i_rx_frame,
	input wire logic [7:0] i_rx_resp_err,
	// diagnostics
	input wire logic i_line_fault,
	input wire logic [link_req_pkg::LOG_AW-1:0] i_log_idx,
	output link_req_pkg::event_s o_log_evt,
	output link_req_pkg::event_s o_err_area,
	output logic o_diag_irq,
	output logic [31:0] o_diag_info,
	output logic o_ext_fault,
	output logic o_ready
);
	import link_req_pkg::*;

	typedef enum logic [3:0] {
		ST_INIT = 4'h1,
		ST_PARAM = 4'h2,
		ST_READY = 4'h4,
		ST_FAIL = 4'h8
	} boot_e;

	typedef enum logic [2:0] {
		RQ_IDLE = 3'h1,
		RQ_XFER = 3'h2,
		RQ_WAIT = 3'h4
	} rq_e;

	boot_e boot_r;
	rq_e rq_r;
	proto_e proto_r;
	logic ready_r;
	logic trig_r;
	logic trig_rise;
	resp_s resp_r;
	event_s err_area_r;
	logic evt_wr;
	event_s evt;
	logic diag_irq_r;
	logic [31:0] diag_info_r;
	logic ext_fault_r;
	logic [15:0] chk;
	logic param_abort;
	logic byte_last_taken;
	logic buf_in_ready;
	logic buf_out_valid;
	byte_s buf_out_data;
	logic rx_pend_r;
	event_s log_rd;

	// returns the allowed length for a kind in the active protocol, 0 if not allowed
	function automatic logic [12:0] len_limit(input proto_e p, input req_kind_e k);
		logic [12:0] lim;
		lim = 13'h0000;
		case (p)
			PROTO_HANDSHAKE: begin
				if (k == REQ_BLOCK_SEND_COORD || k == REQ_BLOCK_SEND_MAILBOX) begin
					lim = LEN_MAX_4K;
				end
			end
			PROTO_COMPUTER_LINK: begin
				case (k)
					REQ_BLOCK_SEND_COORD: lim = LEN_MAX_4K;
					REQ_BLOCK_SEND_MAILBOX: lim = LEN_MAX_LINK_SHORT;
					REQ_REMOTE_WRITE: lim = LEN_MAX_LINK_SHORT;
					REQ_REMOTE_READ: lim = LEN_MAX_LINK_SHORT;
					default: lim = 13'h0000;
				endcase
			end
			PROTO_PRINTER: begin
				if (k == REQ_PRINT) begin
					lim = LEN_MAX_PRINT;
				end
			end
			default: lim = 13'h0000;
		endcase
		return lim;
	endfunction

	// validity check of a new request; STAT_OK when it may proceed
	function automatic logic [15:0] check_req(input proto_e p, input req_s r);
		logic [12:0] lim;
		lim = len_limit(p, r.kind);
		if (r.kind == REQ_BLOCK_RECEIVE) begin
			return STAT_OK;
		end
		if (lim == 13'h0000) begin
			return STAT_BAD_PROTO;
		end
		if (r.length == 13'h0000 || r.length > lim) begin
			return STAT_LENGTH;
		end
		// besides block receive, which returns before this check, only remote write and read may retarget dynamically
		if (r.dyn_addr && r.kind != REQ_REMOTE_WRITE && r.kind != REQ_REMOTE_READ) begin
			return STAT_ACCESS_DENIED;
		end
		return STAT_OK;
	endfunction

	assign trig_rise = i_req_trig && !trig_r;
	assign chk = check_req(proto_r, i_req);
	assign param_abort = i_param_load && (boot_r == ST_INIT);
	assign byte_last_taken = i_tx_valid && buf_in_ready && i_tx_data.last;

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			trig_r <= 1'b0;
		end else begin
			trig_r <= i_req_trig;
		end
	end

	// start-up sequencing; restart kind never reaches this path
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			boot_r <= ST_INIT;
			proto_r <= PROTO_HANDSHAKE;
			ready_r <= 1'b0;
		end else begin
			case (boot_r)
				ST_INIT: begin
					if (i_selftest_fail) begin
						boot_r <= ST_FAIL;
					end else if (i_selftest_done) begin
						boot_r <= ST_PARAM;
					end
				end
				ST_PARAM: begin
					if (i_param_load) begin
						proto_r <= i_param_proto;
						boot_r <= ST_READY;
						ready_r <= 1'b1;
					end
				end
				ST_READY: begin
					if (i_param_load) begin
						proto_r <= i_param_proto;
					end
				end
				ST_FAIL: boot_r <= ST_FAIL;
				default: boot_r <= ST_INIT;
			endcase
		end
	end

	// request sequencing; cold restart aborts, warm restart is not seen at all
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			rq_r <= RQ_IDLE;
			resp_r <= '0;
		end else begin
			resp_r.done <= 1'b0;
			resp_r.error <= 1'b0;
			if (i_cold_restart) begin
				if (rq_r != RQ_IDLE) begin
					resp_r <= '{done: 1'b0, error: 1'b1, status: STAT_RESET_DONE};
				end
				rq_r <= RQ_IDLE;
			end else begin
				case (rq_r)
					RQ_IDLE: begin
						if (trig_rise) begin
							if (!ready_r) begin
								resp_r <= '{done: 1'b0, error: 1'b1, status: STAT_NO_PARAM};
							end else if (chk != STAT_OK) begin
								resp_r <= '{done: 1'b0, error: 1'b1, status: chk};
							end else if (i_req.kind == REQ_BLOCK_RECEIVE) begin
								if (!i_host_run) begin
									resp_r <= '{done: 1'b0, error: 1'b1,
										status: STAT_HOST_STOPPED};
								end else if (rx_pend_r) begin
									resp_r <= '{done: 1'b1, error: 1'b0, status: STAT_OK};
								end else begin
									resp_r <= '{done: 1'b0, error: 1'b1, status: STAT_COMM_FAIL};
								end
							end else begin
								rq_r <= RQ_XFER;
								resp_r.status <= STAT_OK;
							end
						end
					end
					RQ_XFER: begin
						if (trig_rise) begin
							resp_r.status <= STAT_BUSY_WARN;
						end
						if (byte_last_taken) begin
							rq_r <= RQ_WAIT;
						end
					end
					RQ_WAIT: begin
						if (trig_rise) begin
							resp_r.status <= STAT_BUSY_WARN;
						end
						if (i_ser_done) begin
							rq_r <= RQ_IDLE;
							if (i_rx_resp_err != 8'h00) begin
								resp_r <= '{done: 1'b0, error: 1'b1, status: STAT_COMM_FAIL};
							end else begin
								resp_r <= '{done: 1'b1, error: 1'b0, status: STAT_OK};
							end
						end
					end
					default: rq_r <= RQ_IDLE;
				endcase
			end
		end
	end

	// received frames are held even while the host is stopped
	always_ff @(posedge i_clk) begin
		if (i_sys_rst || i_cold_restart) begin
			rx_pend_r <= 1'b0;
		end else if (i_rx_frame) begin
			rx_pend_r <= 1'b1;
		end else if (rq_r == RQ_IDLE && trig_rise && ready_r && i_host_run
			&& i_req.kind == REQ_BLOCK_RECEIVE) begin
			rx_pend_r <= 1'b0;
		end
	end

	skid_buffer2 u_buf (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_flush(i_cold_restart),
		.i_valid(i_tx_valid && rq_r == RQ_XFER),
		.i_data(i_tx_data),
		.o_ready(buf_in_ready),
		.o_valid(buf_out_valid),
		.o_data(buf_out_data),
		.i_ready(i_ser_ready)
	);

	// event selection for the error area and log
	always_comb begin
		evt_wr = 1'b0;
		evt = '0;
		if (param_abort) begin
			evt_wr = 1'b1;
			evt = '{code: EVT_PARAM_ABORT, detail: 16'h0000};
		end else if (i_line_fault || (rq_r == RQ_WAIT && i_ser_done && i_rx_resp_err != 8'h00)) begin
			evt_wr = 1'b1;
			evt = '{code: EVT_DIAG, detail: {8'h00, i_rx_resp_err}};
		end else if (resp_r.error) begin
			evt_wr = 1'b1;
			evt = '{code: EVT_REQ_ERROR, detail: resp_r.status};
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			err_area_r <= '0;
		end else if (evt_wr) begin
			err_area_r <= evt;
		end
	end

	event_log_mem u_log (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_wr(evt_wr),
		.i_wr_evt(evt),
		.i_rd_idx(i_log_idx),
		.o_rd_evt(log_rd),
		.o_wr_ptr()
	);

	// diagnostic interrupt: pulse plus four bytes; fault lamp latches until reset
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			diag_irq_r <= 1'b0;
			diag_info_r <= 32'h0000_0000;
			ext_fault_r <= 1'b0;
		end else begin
			diag_irq_r <= evt_wr && evt.code == EVT_DIAG;
			if (evt_wr && evt.code == EVT_DIAG) begin
				diag_info_r <= {evt.code, 8'h00, evt.detail};
				ext_fault_r <= 1'b1;
			end
		end
	end

	assign o_tx_ready = buf_in_ready && rq_r == RQ_XFER;
	assign o_ser_valid = buf_out_valid;
	assign o_ser_data = buf_out_data;
	assign o_resp = resp_r;
	assign o_log_evt = log_rd;
	assign o_err_area = err_area_r;
	assign o_diag_irq = diag_irq_r;
	assign o_diag_info = diag_info_r;
	assign o_ext_fault = ext_fault_r;
	assign o_ready = ready_r;
endmodule

/* bench/link_req_props.sv */
`timescale 1ns/1ps
module link_req_props
	import link_req_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_req_trig,
	input wire logic i_cold_restart,
	input wire logic i_ser_done,
	input wire logic [7:0] i_rx_resp_err,
	input wire logic o_tx_ready,
	input wire link_req_pkg::resp_s o_resp,
	input wire logic o_ser_valid,
	input wire logic o_diag_irq,
	input wire logic o_ext_fault,
	input wire logic o_ready
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	sequence s_trig_rise;
		i_req_trig && !$past(i_req_trig);
	endsequence
	sequence s_peer_fail;
		i_ser_done && i_rx_resp_err != 8'h00;
	endsequence
	no_param_reject_a: assert property (s_trig_rise ##0 !o_ready |=>
		o_resp.error && o_resp.status == STAT_NO_PARAM) else $error("request while unready passed");
	ok_status_a: assert property (o_resp.done |-> !o_resp.error && o_resp.status == STAT_OK)
		else $error("done without zero status");
	busy_warn_a: assert property (o_resp.status == STAT_BUSY_WARN |-> !o_resp.error)
		else $error("busy warning raised the error flag");
	peer_error_a: assert property (s_peer_fail |=> o_resp.error &&
		o_resp.status == STAT_COMM_FAIL ##[0:1] o_diag_irq) else $error("peer error not reported");
	lamp_on_a: assert property (o_diag_irq |-> ##[0:1] o_ext_fault)
		else $error("fault lamp not lit by diagnostic event");
	lamp_hold_a: assert property (o_ext_fault |=> o_ext_fault)
		else $error("fault lamp dropped without reset");
	cold_abort_a: assert property (i_cold_restart && o_tx_ready |=>
		o_resp.error && o_resp.status == STAT_RESET_DONE) else $error("cold restart left request");
	cold_flush_a: assert property (i_cold_restart |=> !o_ser_valid)
		else $error("buffer not flushed on cold restart");
endmodule

bind serial_link_request_manager link_req_props link_req_props_i (
	.i_clk(i_clk),
	.i_sys_rst(i_sys_rst),
	.i_req_trig(i_req_trig),
	.i_cold_restart(i_cold_restart),
	.i_ser_done(i_ser_done),
	.i_rx_resp_err(i_rx_resp_err),
	.o_tx_ready(o_tx_ready),
	.o_resp(o_resp),
	.o_ser_valid(o_ser_valid),
	.o_diag_irq(o_diag_irq),
	.o_ext_fault(o_ext_fault),
	.o_ready(o_ready)
);

/* bench/serial_peer_model.sv */
`timescale 1ns/1ps
module serial_peer_model
	import link_req_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_stall,
	input wire logic [7:0] i_err,
	input wire logic i_ser_valid,
	input wire link_req_pkg::byte_s i_ser_data,
	output logic o_ser_ready,
	output logic o_ser_done,
	output logic [7:0] o_resp_err,
	output logic [7:0] o_sum
);
	initial begin
		{o_ser_ready, o_ser_done} = 2'b00;
		o_resp_err = 8'h00;
		o_sum = 8'h00;
	end
	// a stalling peer takes a byte only every other cycle
	always @(posedge i_clk) begin
		o_ser_ready <= !i_stall || !o_ser_ready;
		o_ser_done <= 1'b0;
		// error byte is meaningless outside the done pulse, so keep it moving
		o_resp_err <= ~o_resp_err;
		if (i_ser_valid && o_ser_ready) begin
			o_sum <= o_sum + i_ser_data.data;
			if (i_ser_data.last) begin
				o_ser_done <= 1'b1;
				o_resp_err <= i_err;
			end
		end
	end
endmodule

/* bench/test_serial_link_request_manager.sv */
`timescale 1ns/1ps
module test_serial_link_request_manager;
	import link_req_pkg::*;
	logic clk, rst, st_ok, pload, run, cold, trig, txv, txr, sv, sr, sd, rxf, irq, lamp, rdy, stall;
	proto_e proto;
	req_s req;
	byte_s txd, sdat;
	resp_s resp;
	event_s logev, area;
	logic [7:0] rerr, perr, sum, s0;
	logic [31:0] info;
	int n_errors, checks_done;

	serial_link_request_manager serial_link_request_manager_i (.i_clk(clk), .i_sys_rst(rst),
		.i_selftest_done(st_ok), .i_selftest_fail(1'b0), .i_param_load(pload),
		.i_param_proto(proto), .i_host_run(run), .i_cold_restart(cold), .i_req_trig(trig),
		.i_req(req), .i_tx_valid(txv), .i_tx_data(txd), .o_tx_ready(txr), .o_resp(resp),
		.o_ser_valid(sv), .o_ser_data(sdat), .i_ser_ready(sr), .i_ser_done(sd),
		.i_rx_frame(rxf), .i_rx_resp_err(rerr), .i_line_fault(1'b0), .i_log_idx(4'h0),
		.o_log_evt(logev), .o_err_area(area), .o_diag_irq(irq), .o_diag_info(info),
		.o_ext_fault(lamp), .o_ready(rdy));
	serial_peer_model serial_peer_model_i (.i_clk(clk), .i_stall(stall), .i_err(perr),
		.i_ser_valid(sv), .i_ser_data(sdat), .o_ser_ready(sr), .o_ser_done(sd),
		.o_resp_err(rerr), .o_sum(sum));

	always #4 clk = ~clk;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic stop_test;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic issue(input req_kind_e k, input logic [12:0] len, input logic dyn);
		@(negedge clk);
		trig = 1'b0;
		req = '{kind: k, length: len, addr: 16'h0010, dyn_addr: dyn};
		@(negedge clk);
		trig = 1'b1;
	endtask

	// a missing answer counts as a mismatch, not as a quiet pass
	task automatic wait_resp(input logic [15:0] st, input logic er);
		int i;
		for (i = 0; i < 300 && !(resp.done === 1'b1 || resp.error === 1'b1); i++) begin
			@(negedge clk);
		end
		check(resp.done | resp.error, 1'b1);
		check(resp.error, er);
		check(resp.status, st);
		trig = 1'b0;
	endtask

	// bytes 1..n, last flagged on the final one
	task automatic push(input int n);
		int i;
		int w;
		for (i = 1; i <= n; i++) begin
			txv = 1'b1;
			txd = '{last: (i == n), data: 8'(i)};
			for (w = 0; w < 100 && txr !== 1'b1; w++) begin
				@(negedge clk);
			end
			check(txr, 1'b1);
			@(negedge clk);
		end
		txv = 1'b0;
		txd = ~txd;
	endtask

	task automatic rej(input req_kind_e k, input logic [12:0] len, input logic d, input logic [15:0] st);
		issue(k, len, d);
		wait_resp(st, 1'b1);
	endtask

	task automatic t_boot;
		check(rdy, 1'b0);
		rej(REQ_REMOTE_WRITE, 13'h0001, 1'b0, STAT_NO_PARAM);
		pload = 1'b1;
		@(negedge clk);
		pload = 1'b0;
		repeat (3) @(negedge clk);
		check(area.code, EVT_PARAM_ABORT);
		check(logev.code, EVT_PARAM_ABORT);
		check(rdy, 1'b0);
		st_ok = 1'b1;
		@(negedge clk);
		pload = 1'b1;
		@(negedge clk);
		pload = 1'b0;
		repeat (3) @(negedge clk);
		check(rdy, 1'b1);
	endtask

	task automatic t_limits;
		rej(REQ_REMOTE_WRITE, 13'h01C3, 1'b0, STAT_LENGTH);
		rej(REQ_BLOCK_SEND_MAILBOX, 13'h01C3, 1'b0, STAT_LENGTH);
		rej(REQ_BLOCK_SEND_COORD, 13'h1001, 1'b0, STAT_LENGTH);
		rej(REQ_REMOTE_READ, 13'h01C3, 1'b1, STAT_LENGTH);
		rej(REQ_REMOTE_WRITE, 13'h0000, 1'b0, STAT_LENGTH);
		rej(REQ_BLOCK_SEND_COORD, 13'h0001, 1'b1, STAT_ACCESS_DENIED);
		rej(REQ_PRINT, 13'h0001, 1'b0, STAT_BAD_PROTO);
	endtask

	task automatic load(input proto_e p);
		proto = p;
		pload = 1'b1;
		@(negedge clk);
		pload = 1'b0;
	endtask

	// the other two protocols, limits just past the edge, and at the edge for the printer only
	task automatic t_proto;
		load(PROTO_HANDSHAKE);
		rej(REQ_BLOCK_SEND_MAILBOX, 13'h1001, 1'b0, STAT_LENGTH);
		rej(REQ_REMOTE_WRITE, 13'h0001, 1'b0, STAT_BAD_PROTO);
		load(PROTO_PRINTER);
		rej(REQ_PRINT, 13'h0191, 1'b0, STAT_LENGTH);
		rej(REQ_BLOCK_SEND_COORD, 13'h0001, 1'b0, STAT_BAD_PROTO);
		issue(REQ_PRINT, 13'h0190, 1'b0);
		push(1);
		wait_resp(STAT_OK, 1'b0);
		load(PROTO_COMPUTER_LINK);
	endtask

	// host stopped, peer stalling: the started send still completes whole
	task automatic t_send;
		run = 1'b0;
		s0 = sum;
		issue(REQ_REMOTE_WRITE, 13'h01C2, 1'b1);
		push(3);
		wait_resp(STAT_OK, 1'b0);
		check(sum, 8'(s0 + 8'h06));
		run = 1'b1;
	endtask

	task automatic t_busy;
		issue(REQ_BLOCK_SEND_COORD, 13'h1000, 1'b0);
		@(negedge clk);
		trig = 1'b0;
		@(negedge clk);
		trig = 1'b1;
		repeat (2) @(negedge clk);
		check(resp.status, STAT_BUSY_WARN);
		check(resp.error, 1'b0);
		push(2);
		wait_resp(STAT_OK, 1'b0);
	endtask

	task automatic t_peer;
		perr = 8'h05;
		issue(REQ_REMOTE_WRITE, 13'h0001, 1'b0);
		push(1);
		wait_resp(STAT_COMM_FAIL, 1'b1);
		perr = 8'h00;
		repeat (2) @(negedge clk);
		check(lamp, 1'b1);
		check(info[31:24], EVT_DIAG);
		check(info[7:0], 8'h05);
	endtask

	// cold restart while payload is still flowing, one byte in the buffer
	task automatic t_cold;
		issue(REQ_BLOCK_SEND_COORD, 13'h0004, 1'b0);
		@(negedge clk);
		txv = 1'b1;
		txd = '{last: 1'b0, data: 8'h01};
		@(negedge clk);
		txv = 1'b0;
		cold = 1'b1;
		@(negedge clk);
		cold = 1'b0;
		wait_resp(STAT_RESET_DONE, 1'b1);
		check(sv, 1'b0);
	endtask

	task automatic t_rx(input logic r, input logic [15:0] st, input logic er);
		run = r;
		rxf = 1'b1;
		@(negedge clk);
		rxf = 1'b0;
		issue(REQ_BLOCK_RECEIVE, 13'h0001, 1'b0);
		wait_resp(st, er);
		run = 1'b1;
	endtask

	initial begin
		clk = 1'b0;
		{rst, run, stall} = 3'b111;
		{st_ok, pload, cold, trig, txv, rxf} = '0;
		proto = PROTO_COMPUTER_LINK;
		req = '0;
		txd = '0;
		perr = 8'h00;
		repeat (20) @(negedge clk);
		rst = 1'b0;
		t_boot();
		t_limits();
		t_proto();
		t_send();
		t_busy();
		t_peer();
		t_cold();
		t_rx(1'b0, STAT_HOST_STOPPED, 1'b1);
		t_rx(1'b1, STAT_OK, 1'b0);
		rej(REQ_BLOCK_RECEIVE, 13'h0001, 1'b0, STAT_COMM_FAIL);
		stop_test();
	end

	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		stop_test();
	end
endmodule
